// *** bench/hid_feature_cmd_engine_asserts.sv ***
// Port checks for the feature command engine
`timescale 1ns/1ps
module hid_feature_cmd_engine_asserts (
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic       status_nak,
    input  wire logic       get_rpt_rd,
    input  wire logic [4:0] get_rpt_idx,
    input  wire logic [7:0] get_rpt_data,
    input  wire logic       desc_rd,
    input  wire logic [6:0] desc_idx,
    input  wire logic [7:0] desc_data,
    input  wire logic       led_rpt_valid,
    input  wire logic [7:0] led_rpt_data,
    input  wire logic [4:0] led_flags
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    property p_nak_min; $rose(status_nak) |-> status_nak[*3];
    endproperty
    a_nak_min: assert property (p_nak_min) else $error("nak short");
    property p_nak_max; $rose(status_nak) |-> ##[1:26] !status_nak;
    endproperty
    a_nak_max: assert property (p_nak_max) else $error("nak long");
    property p_get_hold; !get_rpt_rd |=> $stable(get_rpt_data);
    endproperty
    a_get_hold: assert property (p_get_hold) else $error("get moved");
    property p_generic; get_rpt_rd && get_rpt_idx == '0 |=> !get_rpt_data[7];
    endproperty
    a_generic: assert property (p_generic) else $error("top bit");
    property p_led; led_rpt_valid |=> led_flags == $past(led_rpt_data[4:0]);
    endproperty
    a_led: assert property (p_led) else $error("led flags");
    property p_led_hold; !led_rpt_valid |=> $stable(led_flags);
    endproperty
    a_led_hold: assert property (p_led_hold) else $error("led moved");
    property p_desc_start; desc_rd && desc_idx == 7'h00 |=> desc_data == 8'h05;
    endproperty
    a_desc_start: assert property (p_desc_start) else $error("desc 0");
    property p_desc_end; desc_rd && desc_idx == 7'h4B |=> desc_data == 8'hC0;
    endproperty
    a_desc_end: assert property (p_desc_end) else $error("desc end");
endmodule : hid_feature_cmd_engine_asserts
bind hid_feature_cmd_engine hid_feature_cmd_engine_asserts chk_u (.clock,
    .sys_rst, .status_nak, .get_rpt_rd, .get_rpt_idx, .get_rpt_data, .desc_rd,
    .desc_idx, .desc_data, .led_rpt_valid, .led_rpt_data, .led_flags);

// *** bench/hid_feature_cmd_engine_tb_top.sv ***
// Self-checking bench for the feature command engine
`timescale 1ns/1ps
module hid_feature_cmd_engine_tb_top;
    logic clock, sys_rst, set_rpt_valid, status_nak, get_rpt_rd, irq;
    logic desc_rd, led_rpt_valid, reg_wr, reg_rd;
    logic [7:0] set_rpt_data, get_rpt_data, desc_data, led_rpt_data, rd_val;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [6:0] desc_idx;
    logic [4:0] get_rpt_idx, led_flags;
    logic [7:0] rs [24];
    int busy, bad_count, check_count, cycles;
    hid_feature_cmd_engine dut_u (.clock, .sys_rst, .set_rpt_valid,
        .set_rpt_data, .status_nak, .get_rpt_rd, .get_rpt_idx, .get_rpt_data,
        .desc_rd, .desc_idx, .desc_data, .led_rpt_valid, .led_rpt_data,
        .led_flags, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
    usb_host_model host_u (.clock, .status_nak, .get_rpt_data, .set_rpt_valid,
        .set_rpt_data, .get_rpt_rd, .get_rpt_idx);
    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            bad_count++;
            report_and_stop();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    task automatic reg_io(input logic wr, input logic [7:0] a, d);
        reg_wr    <= wr;
        reg_rd    <= !wr;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(negedge clock);
        rd_val = reg_rdata;
        @(posedge clock);
    endtask : reg_io
    task automatic irq_is(input logic e);
        @(negedge clock);
        check(8'(irq), 8'(e));
        @(posedge clock);
    endtask : irq_is
    task automatic run(input logic [7:0] c, l, id, input logic [31:0] v);
        logic [7:0] rq [24];
        foreach (rq[k]) rq[k] = 8'h00;
        rq[0] = c;
        rq[1] = l;
        rq[2] = id;
        for (int k = 1; k < l && k < 5; k++) rq[2 + k] = v[32 - 8 * k +: 8];
        host_u.send(rq, int'(l[0]) * 2, busy);
        host_u.fetch(rs);
    endtask : run
    task automatic t_defaults();
        logic [55:0] dfl = 56'h0A_95_63_0D_40_2B_23;
        for (int i = 0; i < 7; i++)
        begin
            run(8'h00, 8'h01, 8'(i < 5 ? i + 2 : i + 3), 32'h0);
            check(rs[0], 8'h00);
            check(rs[1], 8'h01);
            check(rs[2], dfl[55 - 8 * i -: 8]);
            check(rs[3], 8'h00);
            check(8'(busy), 8'h04);
        end
    endtask : t_defaults
    task automatic t_write();
        run(8'h01, 8'h02, 8'h02, 32'h3300_0000);
        check(rs[1], 8'h00);
        check(8'(busy), 8'h04);
        run(8'h00, 8'h01, 8'h02, 32'h0);
        check(rs[2], 8'h33);
        run(8'h01, 8'h04, 8'h01, 32'h3132_3300);
        run(8'h00, 8'h01, 8'h01, 32'h0);
        check(rs[1], 8'h03);
        check(rs[4], 8'h33);
        check(rs[5], 8'h00);
        run(8'h00, 8'h01, 8'h00, 32'h0);
        check(rs[1], 8'h0B);
        check(rs[12], 8'h30);
    endtask : t_write
    task automatic t_errors();
        logic [31:0] tbl [6] = '{32'h02010202, 32'h00010702, 32'h00010F02,
            32'h00000202, 32'h01020001, 32'h01030202};
        foreach (tbl[i])
        begin
            run(tbl[i][31:24], tbl[i][23:16], tbl[i][15:8], 32'h0);
            check(rs[0], tbl[i][7:0]);
            check(rs[1], 8'h00);
            check(8'(busy), 8'h03);
        end
    endtask : t_errors
    task automatic t_regs();
        reg_io(1'b0, hid_cmd_pkg::REG_IRQ_MASK, 8'h00);
        check(rd_val, 8'h00);
        run(8'h00, 8'h01, 8'h02, 32'h0);
        irq_is(1'b0);
        reg_io(1'b1, hid_cmd_pkg::REG_IRQ_MASK, 8'h01);
        irq_is(1'b1);
        reg_io(1'b1, hid_cmd_pkg::REG_IRQ_STAT, 8'h07);
        irq_is(1'b0);
        reg_io(1'b0, 8'hFC, 8'h00);
        check(rd_val, 8'h00);
        reg_io(1'b1, hid_cmd_pkg::REG_CTRL, 8'h00);
        run(8'h00, 8'h01, 8'h02, 32'h0);
        check(rs[0], 8'h01);
        reg_io(1'b1, hid_cmd_pkg::REG_CTRL, 8'h01);
        led_rpt_valid <= 1'b1;
        led_rpt_data  <= 8'hEA;
        @(posedge clock);
        led_rpt_valid <= 1'b0;
        reg_io(1'b0, hid_cmd_pkg::REG_LEDS, 8'h00);
        check({3'h0, led_flags}, 8'h0A);
        check(rd_val, 8'h0A);
        reg_io(1'b0, hid_cmd_pkg::REG_IRQ_STAT, 8'h00);
        check(rd_val, 8'h07);
    endtask : t_regs
    task automatic t_desc();
        logic [15:0] tbl [7] = '{16'h0005, 16'h09E0, 16'h2B03, 16'h4520,
            16'h4718, 16'h4BC0, 16'h4C00};
        foreach (tbl[i])
        begin
            desc_rd  <= 1'b1;
            desc_idx <= tbl[i][14:8];
            @(posedge clock);
            desc_rd <= 1'b0;
            @(negedge clock);
            check(desc_data, tbl[i][7:0]);
            @(posedge clock);
        end
    endtask : t_desc
    initial
    begin
        {sys_rst, desc_rd, reg_wr, reg_rd, led_rpt_valid} = 5'h10;
        {desc_idx, reg_addr, reg_wdata, led_rpt_data} = 31'h0;
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        t_defaults();
        t_write();
        t_errors();
        t_regs();
        t_desc();
        report_and_stop();
    end
endmodule : hid_feature_cmd_engine_tb_top

// *** bench/usb_host_model.sv ***
// Host model: feature request out, response back
`timescale 1ns/1ps
module usb_host_model (
    input  wire logic       clock,
    input  wire logic       status_nak,
    input  wire logic [7:0] get_rpt_data,
    output logic            set_rpt_valid = 1'b0,
    output logic      [7:0] set_rpt_data = 8'h00,
    output logic            get_rpt_rd = 1'b0,
    output logic      [4:0] get_rpt_idx = 5'h00
);
    task automatic send(input logic [7:0] rq [24], input int gap,
                        output int busy);
        busy = 0;
        foreach (rq[k])
        begin
            set_rpt_valid <= 1'b1;
            set_rpt_data  <= rq[k];
            @(posedge clock);
            if (gap > 0 || k == 23)
            begin
                set_rpt_valid <= 1'b0;
                set_rpt_data  <= ~rq[k];
            end
            if (k < 23)
                repeat (gap) @(posedge clock);
        end
        @(negedge clock);
        while (status_nak && busy < 40)
        begin
            busy++;
            @(negedge clock);
        end
        @(posedge clock);
    endtask : send
    task automatic fetch(output logic [7:0] rs [24]);
        get_rpt_rd  <= 1'b1;
        get_rpt_idx <= 5'h00;
        for (int k = 0; k < 24; k++)
        begin
            @(posedge clock);
            get_rpt_idx <= 5'(k + 1);
            if (k == 23)
                get_rpt_rd <= 1'b0;
            @(negedge clock);
            rs[k] = get_rpt_data;
        end
        @(posedge clock);
    endtask : fetch
endmodule : usb_host_model

// *** inc/hid_cmd_pkg.sv ***
// Constants shared by the feature command engine and its setting store
package hid_cmd_pkg;

    // ======
    // Feature report layout
    localparam int unsigned RPT_BYTES = 24;
    localparam logic [4:0]  CODE_OFS  = 5'h00;
    localparam logic [4:0]  LEN_OFS   = 5'h01;
    localparam logic [4:0]  DATA_OFS  = 5'h02;
    localparam logic [4:0]  LAST_OFS  = 5'h17;
    localparam logic [7:0]  DATA_MAX  = 8'h16;

    // ======
    // Commands and generic results
    localparam logic [7:0] CMD_READ     = 8'h00;
    localparam logic [7:0] CMD_WRITE    = 8'h01;
    localparam logic [7:0] RES_OK       = 8'h00;
    localparam logic [7:0] RES_FAIL     = 8'h01;
    localparam logic [7:0] RES_BAD_PARM = 8'h02;

    // ======
    // Settings
    localparam int unsigned SET_COUNT  = 15;
    localparam int unsigned SET_SLOT   = 16;
    localparam logic [7:0]  ID_FW      = 8'h00;
    localparam logic [7:0]  ID_SERIAL  = 8'h01;
    localparam logic [7:0]  ID_POLL    = 8'h02;
    localparam logic [7:0]  ID_LANES   = 8'h03;
    localparam logic [7:0]  ID_FLAGS   = 8'h04;
    localparam logic [7:0]  ID_END     = 8'h05;
    localparam logic [7:0]  ID_L2_WIDE = 8'h06;
    localparam logic [7:0]  ID_RSVD    = 8'h07;
    localparam logic [7:0]  ID_L3_BANK = 8'h08;
    localparam logic [7:0]  ID_L3_LIC  = 8'h09;
    localparam logic [7:0]  ID_LAST    = 8'h0E;
    localparam logic [4:0]  FW_LEN     = 5'h0B;
    localparam logic [4:0]  STR_MAX    = 5'h0F;
    localparam logic [4:0]  BYTE_LEN   = 5'h01;

    // Reset values of byte settings
    localparam logic [7:0] DEF_POLL    = 8'h0A;
    localparam logic [7:0] DEF_LANES   = 8'h95;
    localparam logic [7:0] DEF_FLAGS   = 8'h63;
    localparam logic [7:0] DEF_END     = 8'h0D;
    localparam logic [7:0] DEF_L2_WIDE = 8'h40;
    localparam logic [7:0] DEF_L3_BANK = 8'h2B;
    localparam logic [7:0] DEF_L3_LIC  = 8'h23;

    // ======
    // Report descriptor, first byte in the top bits
    localparam logic [6:0] DESC_LEN = 7'h4C;
    localparam logic [607:0] DESC_ROM = {
        192'h0501_0906_A101_0507_19E0_29E7_1500_2501_7501_9508_8102_9501,
        192'h7508_8103_9505_7501_0508_1901_2905_9102_9501_7503_9103_9506,
        96'h7508_1500_2566_0507_1900_2966,
        96'h8100_26FF_0006_00FF_0920_9518,
        32'hB2_02_01_C0};

    // ======
    // Register map
    localparam logic [7:0] REG_IRQ_STAT = 8'h00;
    localparam logic [7:0] REG_IRQ_MASK = 8'h04;
    localparam logic [7:0] REG_CTRL     = 8'h08;
    localparam logic [7:0] REG_STATE    = 8'h0C;
    localparam logic [7:0] REG_LEDS     = 8'h10;

    localparam int unsigned EV_DONE  = 0;
    localparam int unsigned EV_ERR   = 1;
    localparam int unsigned EV_LED   = 2;
    localparam int unsigned EV_COUNT = 3;
    localparam logic [4:0]  LED_BITS = 5'h1F;

endpackage : hid_cmd_pkg

// *** rtl/hid_feature_cmd_engine.sv ***
// Feature report command interpreter of a keyboard-style card reader
// Notes on behaviour
// RQ1 - Request: command byte 0, valid count byte 1, data bytes 2 to 23.
// RQ2 - Response: result byte 0, valid count byte 1, data bytes 2 to 23.
// RQ3 - Host sends requests by Set_Report, then fetches answers by Get_Report.
// RQ4 - Status stage of Set_Report is refused with NAK until execution ends.
// RQ5 - Command 0 reads a setting, command 1 writes a setting.
// RQ6 - Sender always fills all 22 data bytes, zeros after valid ones.
// RQ7 - Length byte counts valid data bytes; the rest is padding.
// RQ8 - Result codes with top bit clear are generic to all commands.
// RQ9 - Generic results: 0 success, 1 failure, 2 bad parameter or syntax.
// RQ10 - Read carries setting id in data 0; value returned from data 0.
// RQ11 - Write carries id in data 0, value from data 1; no answer data.
// RQ12 - Read and write commands return generic result codes only.
// RQ13 - Setting ids 0 to 14 exist, id 7 is reserved.
// RQ14 - Byte settings hold one byte; string settings bounded, no NUL.
// RQ15 - Keyboard input report: 8 modifier bits, const byte, 6 key slots.
// RQ16 - LED output report: five indicator bits, three padding bits.
// RQ17 - Vendor feature report of 24 bytes carries commands and answers.
// RQ18 - Unknown command or bad setting id answers bad parameter, no data.
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/1ps
module hid_feature_cmd_engine #(
    // Arbitrary identity value
    parameter logic [87:0] FW_IDENT = 88'h30_30_30_30_30_30_30_30_30_30_30
)(
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic       set_rpt_valid,
    input  wire logic [7:0] set_rpt_data,
    output logic            status_nak,
    input  wire logic       get_rpt_rd,
    input  wire logic [4:0] get_rpt_idx,
    output logic      [7:0] get_rpt_data,
    input  wire logic       desc_rd,
    input  wire logic [6:0] desc_idx,
    output logic      [7:0] desc_data,
    input  wire logic       led_rpt_valid,
    input  wire logic [7:0] led_rpt_data,
    output logic      [4:0] led_flags,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            irq
);

    typedef enum {ST_RX, ST_CHECK, ST_COPY, ST_FIN} eng_state_t;

    eng_state_t  state_r;
    logic [7:0]  req_r  [0:hid_cmd_pkg::RPT_BYTES-1];
    logic [7:0]  resp_r [0:hid_cmd_pkg::RPT_BYTES-1];
    logic [4:0]  rx_idx_r;
    logic [4:0]  cnt_r;
    logic [4:0]  todo_r;
    logic [7:0]  result_r;
    logic        is_write_r;
    logic        status_nak_r;
    logic [7:0]  get_rpt_data_r;
    logic [7:0]  desc_data_r;
    logic [4:0]  led_flags_r;
    logic [7:0]  reg_rdata_r;
    logic        irq_r;
    logic [hid_cmd_pkg::EV_COUNT-1:0] irq_stat_r;
    logic [hid_cmd_pkg::EV_COUNT-1:0] irq_mask_r;
    logic [hid_cmd_pkg::EV_COUNT-1:0] ev_nxt;
    logic        enable_r;

    logic [7:0]  cmd;
    logic [7:0]  len;
    logic [7:0]  sid;
    logic [7:0]  check_res;
    logic [4:0]  check_todo;
    logic [4:0]  store_len;
    logic [7:0]  store_byte;
    logic        store_wr;
    logic        store_len_wr;
    logic        rx_take;
    logic        led_take;

    assign status_nak   = status_nak_r;
    assign get_rpt_data = get_rpt_data_r;
    assign desc_data    = desc_data_r;
    assign led_flags    = led_flags_r;
    assign reg_rdata    = reg_rdata_r;
    assign irq          = irq_r;

    assign cmd = req_r[hid_cmd_pkg::CODE_OFS];                        // RQ1
    assign len = req_r[hid_cmd_pkg::LEN_OFS];                         // RQ1
    assign sid = req_r[hid_cmd_pkg::DATA_OFS];                        // RQ10
    assign rx_take  = set_rpt_valid && (state_r == ST_RX);
    assign led_take = led_rpt_valid;

    // ======
    // Setting storage
    setting_store #(
        .FW_IDENT (FW_IDENT)
    ) u_store (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .wr_en     (store_wr),
        .len_wr_en (store_len_wr),
        .wr_id     (sid[3:0]),
        .wr_idx    (cnt_r[3:0]),
        .wr_byte   (req_r[5'(hid_cmd_pkg::DATA_OFS + 5'h01 + cnt_r)]),
        .wr_len    (todo_r),
        .rd_id     (sid[3:0]),
        .rd_idx    (cnt_r[3:0]),
        .rd_byte   (store_byte),
        .rd_len    (store_len)
    );

    assign store_wr     = (state_r == ST_COPY) && is_write_r
                        && (cnt_r < todo_r);                          // RQ11
    assign store_len_wr = (state_r == ST_FIN) && is_write_r
                        && (result_r == hid_cmd_pkg::RES_OK);

    // ======
    // Request checking
    always_comb
    begin
        check_res  = hid_cmd_pkg::RES_OK;
        check_todo = 5'h00;
        if (!enable_r)
            check_res = hid_cmd_pkg::RES_FAIL;                        // RQ9
        else if (cmd != hid_cmd_pkg::CMD_READ
              && cmd != hid_cmd_pkg::CMD_WRITE)
            check_res = hid_cmd_pkg::RES_BAD_PARM;                    // RQ18
        else if (len == 8'h00 || len > hid_cmd_pkg::DATA_MAX)
            check_res = hid_cmd_pkg::RES_BAD_PARM;                    // RQ7
        else if (sid > hid_cmd_pkg::ID_LAST
              || sid == hid_cmd_pkg::ID_RSVD)
            check_res = hid_cmd_pkg::RES_BAD_PARM;                    // RQ13
        else if (cmd == hid_cmd_pkg::CMD_READ)
            check_todo = store_len;                                   // RQ10
        else if (sid == hid_cmd_pkg::ID_FW)
            check_res = hid_cmd_pkg::RES_FAIL;                        // RQ9
        else if (sid == hid_cmd_pkg::ID_SERIAL)
        begin
            if (len - 8'h01 > {3'b000, hid_cmd_pkg::STR_MAX})
                check_res = hid_cmd_pkg::RES_BAD_PARM;                // RQ14
            else
                check_todo = 5'(len - 8'h01);
        end
        else if (len != 8'h02)
            check_res = hid_cmd_pkg::RES_BAD_PARM;                    // RQ14
        else
            check_todo = hid_cmd_pkg::BYTE_LEN;                       // RQ14
    end

    // ======
    // Command sequencer
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_r    <= ST_RX;
            rx_idx_r   <= 5'h00;
            cnt_r      <= 5'h00;
            todo_r     <= 5'h00;
            result_r   <= hid_cmd_pkg::RES_OK;
            is_write_r <= 1'b0;
        end
        else
        begin
            case (state_r)
                ST_RX:
                begin
                    if (rx_take)
                    begin
                        if (rx_idx_r == hid_cmd_pkg::LAST_OFS)
                        begin
                            rx_idx_r <= 5'h00;
                            state_r  <= ST_CHECK;
                        end
                        else
                            rx_idx_r <= rx_idx_r + 5'h01;
                    end
                end
                ST_CHECK:
                begin
                    result_r   <= check_res;                          // RQ12
                    todo_r     <= (check_res == hid_cmd_pkg::RES_OK)
                                ? check_todo : 5'h00;
                    is_write_r <= (cmd == hid_cmd_pkg::CMD_WRITE);    // RQ5
                    cnt_r      <= 5'h00;
                    state_r    <= ST_COPY;
                end
                ST_COPY:
                begin
                    if (cnt_r >= todo_r)
                        state_r <= ST_FIN;
                    else
                        cnt_r <= cnt_r + 5'h01;
                end
                ST_FIN:
                begin
                    state_r <= ST_RX;
                end
                default:
                    state_r <= ST_RX;
            endcase
        end
    end

    // ======
    // Request buffer
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < hid_cmd_pkg::RPT_BYTES; i++)
                req_r[i] <= 8'h00;
        end
        else if (rx_take)
            req_r[rx_idx_r] <= set_rpt_data;                          // RQ6
    end

    // ======
    // Status stage refused from last request byte until finish
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            status_nak_r <= 1'b0;
        else if (rx_take && rx_idx_r == hid_cmd_pkg::LAST_OFS)
            status_nak_r <= 1'b1;                                     // RQ4
        else if (state_r == ST_FIN)
            status_nak_r <= 1'b0;                                     // RQ4
    end

    // ======
    // Response buffer; unused bytes stay zero
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < hid_cmd_pkg::RPT_BYTES; i++)
                resp_r[i] <= 8'h00;
        end
        else if (state_r == ST_CHECK)
        begin
            for (int i = 0; i < hid_cmd_pkg::RPT_BYTES; i++)
                resp_r[i] <= 8'h00;                                   // RQ2
        end
        else if (state_r == ST_COPY && !is_write_r && cnt_r < todo_r)
            resp_r[5'(hid_cmd_pkg::DATA_OFS + cnt_r)] <= store_byte;  // RQ10
        else if (state_r == ST_FIN)
        begin
            resp_r[hid_cmd_pkg::CODE_OFS] <= result_r;                // RQ8
            resp_r[hid_cmd_pkg::LEN_OFS]  <= is_write_r ? 8'h00
                                          : {3'b000, todo_r};         // RQ11
        end
    end

    // ======
    // Get_Report read port
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            get_rpt_data_r <= 8'h00;
        else if (get_rpt_rd)
            get_rpt_data_r <= (get_rpt_idx <= hid_cmd_pkg::LAST_OFS)
                            ? resp_r[get_rpt_idx] : 8'h00;            // RQ17
    end

    // ======
    // Report descriptor: keyboard, LEDs and vendor feature report
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            desc_data_r <= 8'h00;
        else if (desc_rd)
        begin
            if (desc_idx < hid_cmd_pkg::DESC_LEN)
                desc_data_r <= hid_cmd_pkg::DESC_ROM[
                    8*(int'(hid_cmd_pkg::DESC_LEN) - 1 - int'(desc_idx)) +: 8
                ];                                                    // RQ15
            else
                desc_data_r <= 8'h00;
        end
    end

    // ======
    // LED report: five flags kept, padding dropped
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            led_flags_r <= 5'h00;
        else if (led_take)
            led_flags_r <= led_rpt_data[4:0] & hid_cmd_pkg::LED_BITS;  // RQ16
    end

    // ======
    // Interrupt events
    always_comb
    begin
        ev_nxt = '0;
        ev_nxt[hid_cmd_pkg::EV_DONE] = (state_r == ST_FIN);
        ev_nxt[hid_cmd_pkg::EV_ERR]  = (state_r == ST_FIN)
                                    && (result_r != hid_cmd_pkg::RES_OK);
        ev_nxt[hid_cmd_pkg::EV_LED]  = led_take
                                    && (led_rpt_data[4:0] != led_flags_r);
    end

    // Sticky status, write one to clear; a new event wins
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            irq_stat_r <= '0;
        else if (reg_wr && reg_addr == hid_cmd_pkg::REG_IRQ_STAT)
            irq_stat_r <= (irq_stat_r
                        & ~reg_wdata[hid_cmd_pkg::EV_COUNT-1:0]) | ev_nxt;
        else
            irq_stat_r <= irq_stat_r | ev_nxt;
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            irq_r <= 1'b0;
        else
            irq_r <= |(irq_stat_r & irq_mask_r);
    end

    // ======
    // Writable registers
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irq_mask_r <= '0;
            enable_r   <= 1'b1;
        end
        else if (reg_wr)
        begin
            if (reg_addr == hid_cmd_pkg::REG_IRQ_MASK)
                irq_mask_r <= reg_wdata[hid_cmd_pkg::EV_COUNT-1:0];
            else if (reg_addr == hid_cmd_pkg::REG_CTRL)
                enable_r <= reg_wdata[0];
        end
    end

    // ======
    // Register read, data in the following cycle
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            reg_rdata_r <= 8'h00;
        else if (reg_rd)
        begin
            if (reg_addr == hid_cmd_pkg::REG_IRQ_STAT)
                reg_rdata_r <= {5'h00, irq_stat_r};
            else if (reg_addr == hid_cmd_pkg::REG_IRQ_MASK)
                reg_rdata_r <= {5'h00, irq_mask_r};
            else if (reg_addr == hid_cmd_pkg::REG_CTRL)
                reg_rdata_r <= {7'h00, enable_r};
            else if (reg_addr == hid_cmd_pkg::REG_STATE)
                reg_rdata_r <= {status_nak_r, result_r[6:0]};
            else if (reg_addr == hid_cmd_pkg::REG_LEDS)
                reg_rdata_r <= {3'h0, led_flags_r};
            else
                reg_rdata_r <= 8'h00;
        end
        else
            reg_rdata_r <= 8'h00;
    end

endmodule : hid_feature_cmd_engine

// *** rtl/setting_store.sv ***
// Storage for the device settings, one slot of bytes plus a length each
`timescale 1ns/1ps
module setting_store #(
    // Arbitrary identity value
    parameter logic [87:0] FW_IDENT = 88'h30_30_30_30_30_30_30_30_30_30_30
)(
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic       wr_en,
    input  wire logic       len_wr_en,
    input  wire logic [3:0] wr_id,
    input  wire logic [3:0] wr_idx,
    input  wire logic [7:0] wr_byte,
    input  wire logic [4:0] wr_len,
    input  wire logic [3:0] rd_id,
    input  wire logic [3:0] rd_idx,
    output logic      [7:0] rd_byte,
    output logic      [4:0] rd_len
);

    logic [7:0] mem_r [0:hid_cmd_pkg::SET_COUNT*hid_cmd_pkg::SET_SLOT-1];
    logic [4:0] len_r [0:hid_cmd_pkg::SET_COUNT-1];

    function automatic logic [7:0] byte_default(input logic [7:0] id);
        case (id)
            hid_cmd_pkg::ID_POLL:    byte_default = hid_cmd_pkg::DEF_POLL;
            hid_cmd_pkg::ID_LANES:   byte_default = hid_cmd_pkg::DEF_LANES;
            hid_cmd_pkg::ID_FLAGS:   byte_default = hid_cmd_pkg::DEF_FLAGS;
            hid_cmd_pkg::ID_END:     byte_default = hid_cmd_pkg::DEF_END;
            hid_cmd_pkg::ID_L2_WIDE: byte_default = hid_cmd_pkg::DEF_L2_WIDE;
            hid_cmd_pkg::ID_L3_BANK: byte_default = hid_cmd_pkg::DEF_L3_BANK;
            hid_cmd_pkg::ID_L3_LIC:  byte_default = hid_cmd_pkg::DEF_L3_LIC;
            default:                 byte_default = 8'h00;
        endcase
    endfunction : byte_default

    // ======
    // Value bytes; serial starts empty, byte settings at defaults
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < $size(mem_r); i++)
                mem_r[i] <= (i % hid_cmd_pkg::SET_SLOT == 0)
                    ? byte_default(8'(i / hid_cmd_pkg::SET_SLOT)) : 8'h00;
        end
        else if (wr_en)
            mem_r[{wr_id, wr_idx}] <= wr_byte;
    end

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < hid_cmd_pkg::SET_COUNT; i++)
                len_r[i] <= (i == int'(hid_cmd_pkg::ID_SERIAL)) ? 5'h00
                          : hid_cmd_pkg::BYTE_LEN;
        end
        else if (len_wr_en)
            len_r[wr_id] <= wr_len;
    end

    // ======
    // Read port; firmware identity is fixed
    always_comb
    begin
        if (rd_id == hid_cmd_pkg::ID_FW[3:0])
        begin
            rd_byte = (rd_idx < hid_cmd_pkg::FW_LEN[3:0])
                    ? FW_IDENT[8*(10-int'(rd_idx)) +: 8] : 8'h00;
            rd_len  = hid_cmd_pkg::FW_LEN;
        end
        else
        begin
            rd_byte = mem_r[{rd_id, rd_idx}];
            rd_len  = len_r[rd_id];
        end
    end

endmodule : setting_store
